// *** design/mio_pin_sync.sv ***
// three-stage synchroniser for a group of pin inputs, change taken when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module mio_pin_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // raw pins and filtered level
  input  wire logic [W-1:0] pin_raw,
  output logic      [W-1:0] pin_level
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  ////////////////////////////////////////////////////////////////////////////
  // shift chain; stage1 feeds stage2 only
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept a bit change once two later stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_level <= '0;
    end else begin
      pin_level <= (stage2 & stage3) | (pin_level & (stage2 | stage3));
    end
  end
endmodule : mio_pin_sync
`default_nettype wire

// *** design/mio_pkg.sv ***
// package with register map, field layout and reset values of the multifunction io port block
package mio_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register index within the port configuration block, per port
  localparam logic [3:0] MIO_REG_SAMPLE = 4'h0;
  localparam logic [3:0] MIO_REG_OUTVAL = 4'h1;
  localparam logic [3:0] MIO_REG_OEN    = 4'h2;
  localparam logic [3:0] MIO_REG_DRIVE  = 4'h3;
  // port select field of the register address
  localparam logic [1:0] MIO_PORT_ONE   = 2'h0;
  localparam logic [1:0] MIO_PORT_TWO   = 2'h1;
  localparam logic [1:0] MIO_PORT_THREE = 2'h2;
  // address layout: addr[5:4] port, addr[3:0] register
  localparam int MIO_ADDR_W        = 6;
  localparam int MIO_PORT_LSB      = 4;
  // port widths
  localparam int MIO_WIDE_W        = 8;
  localparam int MIO_NARROW_W      = 3;
  // reset value of every configuration register
  localparam logic [7:0] MIO_CFG_RESET = 8'h00;
  // first port drive-select split: low nibble slew, high nibble open drain
  localparam logic [7:0] MIO_ONE_SLEW_MASK = 8'h0F;
  localparam logic [7:0] MIO_ONE_OD_MASK   = 8'hF0;
  // third port implemented bit mask
  localparam logic [7:0] MIO_THREE_MASK    = 8'h07;
  // third port pin roles
  localparam int MIO_CLK_PIN       = 1;
  localparam int MIO_SEL_PIN       = 2;
endpackage : mio_pkg

// *** design/mio_port_block.sv ***
// top of the multifunction io port block: host registers, pin muxing and logic-array routing
//
// Behaviour
// - sample register reads the real level on each pin, whoever drives it
// - bit n of each port register maps to pin n of that port
// - sample registers are readable anytime and ignore writes
// - output-value register is read/write; readback returns last value written; third port keeps only bits 2..0 of it
// - software output drives pin low for 0 and high for 1
// - logic-driven pins ignore the output-value register; logic output overrides
// - without product term, direction 1 means output and 0 means input
// - with product term, pin is output if direction or term is one
// - third port direction register holds only three low bits
// - open-drain select 1 drives low and releases high; 0 is push-pull
// - slew select 1 gives fast slew, 0 standard slew by default
// - first port: drive bits 3..0 slew, bits 7..4 open drain
// - second port: every drive bit selects open drain, no slew control
// - third port: drive bits 2..0 fast slew, bits 7..3 not applicable
// - first port takes either macrocell group; second port only shared group
// - wide ports enter the array via input cells; third port directly
// - second port can be handed over to the boundary-scan programming port
// - third port middle pin can clock the output cell flip-flops
// - third port top pin high disables flash and puts it in standby
// - three external selects on third port, one term each, selectable polarity
// - external select driver enabled by its product term or direction bit
// - registers are reached by ordinary host read and write cycles
`timescale 1ns/1ps
`default_nettype none
module mio_port_block
  import mio_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // host register port
  input  wire logic                    reg_sel,
  input  wire logic                    reg_wr,
  input  wire logic [MIO_ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  // first 8-bit port pins
  input  wire logic [MIO_WIDE_W-1:0]   one_pin_in,
  output logic      [MIO_WIDE_W-1:0]   one_pin_out,
  output logic      [MIO_WIDE_W-1:0]   one_pin_oe,
  output logic      [MIO_WIDE_W-1:0]   one_pin_fast,
  // second 8-bit port pins
  input  wire logic [MIO_WIDE_W-1:0]   two_pin_in,
  output logic      [MIO_WIDE_W-1:0]   two_pin_out,
  output logic      [MIO_WIDE_W-1:0]   two_pin_oe,
  // third 3-bit port pins
  input  wire logic [MIO_NARROW_W-1:0] three_pin_in,
  output logic      [MIO_NARROW_W-1:0] three_pin_out,
  output logic      [MIO_NARROW_W-1:0] three_pin_oe,
  output logic      [MIO_NARROW_W-1:0] three_pin_fast,
  // programmable logic configuration
  input  wire logic [MIO_WIDE_W-1:0]   one_logic_owned,
  input  wire logic [MIO_WIDE_W-1:0]   one_use_shared,
  input  wire logic [MIO_WIDE_W-1:0]   two_logic_owned,
  input  wire logic [MIO_NARROW_W-1:0] three_select_owned,
  input  wire logic [MIO_NARROW_W-1:0] select_active_low,
  input  wire logic                    scan_port_enable,
  input  wire logic                    clock_pin_assign,
  input  wire logic                    select_pin_assign,
  // programmable logic array signals
  input  wire logic [MIO_WIDE_W-1:0]   port_one_macrocell_group,
  input  wire logic [MIO_WIDE_W-1:0]   shared_macrocell_group,
  input  wire logic [MIO_WIDE_W-1:0]   one_oe_term,
  input  wire logic [MIO_WIDE_W-1:0]   two_oe_term,
  input  wire logic [MIO_NARROW_W-1:0] three_oe_term,
  input  wire logic [MIO_NARROW_W-1:0] select_term,
  output logic      [MIO_WIDE_W-1:0]   one_input_cell,
  output logic      [MIO_WIDE_W-1:0]   two_input_cell,
  output logic      [MIO_NARROW_W-1:0] three_array_in,
  // boundary-scan programming port
  input  wire logic [MIO_WIDE_W-1:0]   scan_pin_out,
  input  wire logic [MIO_WIDE_W-1:0]   scan_pin_oe,
  output logic      [MIO_WIDE_W-1:0]   scan_pin_in,
  // dedicated functions of the third port
  output logic                         logic_clock_input,
  output logic                         flash_standby
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] one_outval;
  logic [7:0] one_dir;
  logic [7:0] one_drive;
  logic [7:0] two_outval;
  logic [7:0] two_dir;
  logic [7:0] two_drive;
  logic [7:0] three_outval;
  logic [7:0] three_dir;
  logic [7:0] three_drive;
  logic [MIO_WIDE_W-1:0]   one_level;
  logic [MIO_WIDE_W-1:0]   two_level;
  logic [MIO_NARROW_W-1:0] three_level;
  logic [1:0] acc_port;
  logic [3:0] acc_reg;
  logic       wr_en;
  logic [MIO_WIDE_W-1:0]   one_data;
  logic [MIO_WIDE_W-1:0]   one_en;
  logic [MIO_WIDE_W-1:0]   one_od;
  logic [MIO_WIDE_W-1:0]   two_data;
  logic [MIO_WIDE_W-1:0]   two_en;
  logic [MIO_NARROW_W-1:0] three_data;
  logic [MIO_NARROW_W-1:0] three_en;
  logic [MIO_NARROW_W-1:0] select_value;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, one per port
  mio_pin_sync #(.W(MIO_WIDE_W)) u_sync_one (
    .clk       (clk),
    .rst       (rst),
    .pin_raw   (one_pin_in),
    .pin_level (one_level)
  );

  mio_pin_sync #(.W(MIO_WIDE_W)) u_sync_two (
    .clk       (clk),
    .rst       (rst),
    .pin_raw   (two_pin_in),
    .pin_level (two_level)
  );

  mio_pin_sync #(.W(MIO_NARROW_W)) u_sync_three (
    .clk       (clk),
    .rst       (rst),
    .pin_raw   (three_pin_in),
    .pin_level (three_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign acc_port = reg_addr[MIO_ADDR_W-1:MIO_PORT_LSB];
  assign acc_reg  = reg_addr[MIO_PORT_LSB-1:0];
  assign wr_en    = reg_sel & reg_wr;

  // first port register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      one_outval <= MIO_CFG_RESET;
      one_dir    <= MIO_CFG_RESET;
      one_drive  <= MIO_CFG_RESET;
    end else if (wr_en && acc_port == MIO_PORT_ONE) begin
      case (acc_reg)
        MIO_REG_OUTVAL: one_outval <= reg_wdata;
        MIO_REG_OEN:    one_dir    <= reg_wdata;
        MIO_REG_DRIVE:  one_drive  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // second port register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      two_outval <= MIO_CFG_RESET;
      two_dir    <= MIO_CFG_RESET;
      two_drive  <= MIO_CFG_RESET;
    end else if (wr_en && acc_port == MIO_PORT_TWO) begin
      case (acc_reg)
        MIO_REG_OUTVAL: two_outval <= reg_wdata;
        MIO_REG_OEN:    two_dir    <= reg_wdata;
        MIO_REG_DRIVE:  two_drive  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // third port register writes, only three low bits kept
  always_ff @(posedge clk) begin
    if (rst) begin
      three_outval <= MIO_CFG_RESET;
      three_dir    <= MIO_CFG_RESET;
      three_drive  <= MIO_CFG_RESET;
    end else if (wr_en && acc_port == MIO_PORT_THREE) begin
      case (acc_reg)
        MIO_REG_OUTVAL: three_outval <= reg_wdata & MIO_THREE_MASK;
        MIO_REG_OEN:    three_dir    <= reg_wdata & MIO_THREE_MASK;
        MIO_REG_DRIVE:  three_drive  <= reg_wdata & MIO_THREE_MASK;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, combinational so data comes back in the access cycle
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_sel && !reg_wr) begin
      case (acc_port)
        MIO_PORT_ONE: begin
          case (acc_reg)
            MIO_REG_SAMPLE: reg_rdata = one_level;
            MIO_REG_OUTVAL: reg_rdata = one_outval;
            MIO_REG_OEN:    reg_rdata = one_dir;
            MIO_REG_DRIVE:  reg_rdata = one_drive;
            default:        reg_rdata = 8'h00;
          endcase
        end
        MIO_PORT_TWO: begin
          case (acc_reg)
            MIO_REG_SAMPLE: reg_rdata = two_level;
            MIO_REG_OUTVAL: reg_rdata = two_outval;
            MIO_REG_OEN:    reg_rdata = two_dir;
            MIO_REG_DRIVE:  reg_rdata = two_drive;
            default:        reg_rdata = 8'h00;
          endcase
        end
        MIO_PORT_THREE: begin
          case (acc_reg)
            MIO_REG_SAMPLE: reg_rdata = {5'h00, three_level};
            MIO_REG_OUTVAL: reg_rdata = three_outval;
            MIO_REG_OEN:    reg_rdata = three_dir;
            MIO_REG_DRIVE:  reg_rdata = three_drive;
            default:        reg_rdata = 8'h00;
          endcase
        end
        default: reg_rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first port: data source, enable and drive style, per bit
  assign one_data = one_logic_owned & (one_use_shared & shared_macrocell_group
                  | ~one_use_shared & port_one_macrocell_group)
                  | ~one_logic_owned & one_outval;
  assign one_en   = one_dir | one_oe_term;
  assign one_od   = one_drive & MIO_ONE_OD_MASK;

  // open drain releases the pin for a high
  always_ff @(posedge clk) begin
    if (rst) begin
      one_pin_out  <= '0;
      one_pin_oe   <= '0;
      one_pin_fast <= '0;
    end else begin
      one_pin_out  <= one_data & ~one_od;
      one_pin_oe   <= one_en & ~(one_od & one_data);
      one_pin_fast <= one_drive & MIO_ONE_SLEW_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second port: shared group only, all open-drain capable, scan takeover
  assign two_data = two_logic_owned & shared_macrocell_group | ~two_logic_owned & two_outval;
  assign two_en   = two_dir | two_oe_term;

  always_ff @(posedge clk) begin
    if (rst) begin
      two_pin_out <= '0;
      two_pin_oe  <= '0;
    end else if (scan_port_enable) begin
      two_pin_out <= scan_pin_out;
      two_pin_oe  <= scan_pin_oe;
    end else begin
      two_pin_out <= two_data & ~two_drive;
      two_pin_oe  <= two_en & ~(two_drive & two_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // third port: external selects with polarity, else software value
  assign select_value = select_term ^ select_active_low;
  assign three_data   = three_select_owned & select_value | ~three_select_owned & three_outval[2:0];
  assign three_en     = three_dir[2:0] | three_oe_term;

  always_ff @(posedge clk) begin
    if (rst) begin
      three_pin_out  <= '0;
      three_pin_oe   <= '0;
      three_pin_fast <= '0;
    end else begin
      three_pin_out  <= three_data;
      three_pin_oe   <= three_en;
      three_pin_fast <= three_drive[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing into the logic array and dedicated third-port functions
  always_ff @(posedge clk) begin
    if (rst) begin
      one_input_cell    <= '0;
      two_input_cell    <= '0;
      three_array_in    <= '0;
      scan_pin_in       <= '0;
      logic_clock_input <= 1'b0;
      flash_standby     <= 1'b0;
    end else begin
      one_input_cell    <= one_level;
      two_input_cell    <= scan_port_enable ? '0 : two_level;
      three_array_in    <= three_level;
      scan_pin_in       <= scan_port_enable ? two_level : '0;
      logic_clock_input <= clock_pin_assign & three_level[MIO_CLK_PIN];
      flash_standby     <= select_pin_assign & three_level[MIO_SEL_PIN];
    end
  end
endmodule : mio_port_block
`default_nettype wire

// *** sim/mio_pin_world.sv ***
// pin-side model: resolves each pin level from block drive and outside sources
`timescale 1ns/1ps
`default_nettype none
module mio_pin_world (
  // block drive
  input  wire logic [7:0] one_out,
  input  wire logic [7:0] one_oe,
  input  wire logic [7:0] two_out,
  input  wire logic [7:0] two_oe,
  input  wire logic [2:0] three_out,
  input  wire logic [2:0] three_oe,
  // outside level, pull-up or external driver
  input  wire logic [7:0] one_ext,
  input  wire logic [7:0] two_ext,
  input  wire logic [2:0] three_ext,
  // resolved pin levels
  output logic      [7:0] one_lvl,
  output logic      [7:0] two_lvl,
  output logic      [2:0] three_lvl
);
  // block wins where enabled, outside level elsewhere
  assign one_lvl   = (one_oe & one_out) | (~one_oe & one_ext);
  assign two_lvl   = (two_oe & two_out) | (~two_oe & two_ext);
  assign three_lvl = (three_oe & three_out) | (~three_oe & three_ext);
endmodule : mio_pin_world
`default_nettype wire

// *** sim/mio_port_block_properties.sv ***
// concurrent checks on the ports of the multifunction io port block
`timescale 1ns/1ps
`default_nettype none
module mio_port_block_properties (
  // clock, reset, host port
  input wire logic       clk, rst, reg_sel, reg_wr,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  // pins and array signals
  input wire logic [7:0] one_pin_out, one_pin_oe, two_pin_oe, one_logic_owned, one_use_shared,
  input wire logic [7:0] port_one_macrocell_group, one_oe_term, scan_pin_in,
  input wire logic [2:0] three_pin_out, three_pin_oe, three_select_owned, select_term, select_active_low,
  input wire logic       scan_port_enable, clock_pin_assign, logic_clock_input, select_pin_assign, flash_standby
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // host side and pin drive after reset
  property p_rd_idle; !(reg_sel && !reg_wr) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
  property p_readback;
    reg_sel && reg_wr && reg_addr == 6'h01 ##1 reg_sel && !reg_wr && reg_addr == 6'h01 |-> reg_rdata == $past(reg_wdata);
  endproperty
  a_readback: assert property (p_readback) else $error("output value readback differs");
  property p_three_mask; reg_sel && !reg_wr && reg_addr == 6'h22 |-> reg_rdata[7:3] == 5'h00; endproperty
  a_three_mask: assert property (p_three_mask) else $error("third port direction upper bits set");
  property p_reset; disable iff (1'b0) rst |=> one_pin_oe == 8'h00 && two_pin_oe == 8'h00 && three_pin_oe == 3'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("pin drive enabled after reset");
  ////////////////////////////////////////////////////////////////////////////
  // pin side, one edge behind its cause
  property p_oe_term;
    !$past(rst) && !$past(rst, 2) && &one_oe_term[3:0] && &$past(one_oe_term[3:0]) |-> &one_pin_oe[3:0];
  endproperty
  a_oe_term: assert property (p_oe_term) else $error("product term did not enable pins");
  property p_owned;
    !$past(rst) && $past(one_logic_owned[0]) && !$past(one_use_shared[0])
      |-> one_pin_out[0] == $past(port_one_macrocell_group[0]);
  endproperty
  a_owned: assert property (p_owned) else $error("macrocell did not override pin");
  property p_sel_pol;
    !$past(rst) && $past(three_select_owned[0]) |-> three_pin_out[0] == ($past(select_term[0]) ^ $past(select_active_low[0]));
  endproperty
  a_sel_pol: assert property (p_sel_pol) else $error("external select polarity wrong");
  property p_clk_pin; !clock_pin_assign && !$past(clock_pin_assign) |-> !logic_clock_input; endproperty
  a_clk_pin: assert property (p_clk_pin) else $error("logic clock active while unassigned");
  property p_stby; !select_pin_assign && !$past(select_pin_assign) |-> !flash_standby; endproperty
  a_stby: assert property (p_stby) else $error("standby active while unassigned");
  property p_scan; !scan_port_enable && !$past(scan_port_enable) |-> scan_pin_in == 8'h00; endproperty
  a_scan: assert property (p_scan) else $error("scan input live outside scan mode");
endmodule : mio_port_block_properties
bind mio_port_block mio_port_block_properties u_props (.*);
`default_nettype wire

// *** sim/mio_port_block_tb.sv ***
// register-level testbench of the multifunction io port block
`timescale 1ns/1ps
`default_nettype none
module mio_port_block_tb;
  import mio_pkg::*;
  logic clk = 1'b0;
  logic rst, reg_sel, reg_wr, scan_port_enable, clock_pin_assign, select_pin_assign, logic_clock_input, flash_standby;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, one_pin_in, one_pin_out, one_pin_oe, one_pin_fast, two_pin_in, two_pin_out;
  logic [7:0] two_pin_oe, one_logic_owned, one_use_shared, two_logic_owned, port_one_macrocell_group;
  logic [7:0] shared_macrocell_group, one_oe_term, two_oe_term, one_input_cell, two_input_cell;
  logic [7:0] scan_pin_out, scan_pin_oe, scan_pin_in, one_ext, two_ext;
  logic [2:0] three_pin_in, three_pin_out, three_pin_oe, three_pin_fast, three_select_owned, select_active_low;
  logic [2:0] three_oe_term, select_term, three_array_in, three_ext;
  int n_mismatch = 0;
  int n_compared = 0;
  mio_port_block dut (.*);
  mio_pin_world u_world (.one_out(one_pin_out), .one_oe(one_pin_oe), .two_out(two_pin_out), .two_oe(two_pin_oe),
    .three_out(three_pin_out), .three_oe(three_pin_oe), .one_ext(one_ext), .two_ext(two_ext),
    .three_ext(three_ext), .one_lvl(one_pin_in), .two_lvl(two_pin_in), .three_lvl(three_pin_in));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // host access and compare tasks
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_sel, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
  endtask : wr
  task rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge clk);
    {reg_sel, reg_wr, reg_addr} = {2'b10, a};
    #1 chk(reg_rdata, e);
  endtask : rd
  task idle(input int n);
    @(negedge clk);
    {reg_sel, reg_wr} = 2'b00;
    repeat (n) @(negedge clk);
  endtask : idle
  task summarize;
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #100us;
    n_mismatch++;
    summarize();
  end
  // main sequence
  initial begin
    {reg_sel, reg_wr, reg_addr, reg_wdata, scan_port_enable, clock_pin_assign, select_pin_assign} = '0;
    {one_logic_owned, one_use_shared, two_logic_owned, port_one_macrocell_group, shared_macrocell_group} = '0;
    {one_oe_term, two_oe_term, scan_pin_out, scan_pin_oe, three_select_owned, select_active_low} = '0;
    {three_oe_term, select_term, three_ext} = '0;
    {rst, one_ext, two_ext} = {1'b1, 8'h3C, 8'hFF};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk(one_pin_oe, 8'h00);
    chk({two_pin_oe[6:0], three_pin_fast[0]}, 8'h00);
    for (int p = 0; p < 3; p++) for (int r = 1; r < 4; r++) rd(6'(p * 16 + r), 8'h00);
    idle(8);
    rd(6'h00, 8'h3C);
    rd(6'h10, 8'hFF);
    wr(6'h00, 8'h00);
    rd(6'h00, 8'h3C);
    wr(6'h01, 8'hA5);
    rd(6'h01, 8'hA5);
    wr(6'h22, 8'hFF);
    rd(6'h22, 8'h07);
    wr(6'h02, 8'hFF);
    idle(2);
    chk(one_pin_oe, 8'hFF);
    chk(one_pin_out, 8'hA5);
    idle(6);
    rd(6'h00, 8'hA5);
    // open drain on high nibble: zeros driven, ones released
    wr(6'h03, 8'hF0);
    idle(2);
    chk(one_pin_oe, 8'h5F);
    chk(one_pin_out & one_pin_oe, 8'h05);
    chk(one_pin_fast, 8'h00);
    wr(6'h03, 8'h0F);
    idle(2);
    chk(one_pin_fast, 8'h0F);
    wr(6'h12, 8'hFF);
    wr(6'h13, 8'hFF);
    wr(6'h11, 8'h0F);
    wr(6'h23, 8'hFF);
    idle(2);
    chk(two_pin_oe, 8'hF0);
    chk(two_pin_out & two_pin_oe, 8'h00);
    chk({5'h00, three_pin_fast}, 8'h07);
    chk({5'h00, three_pin_oe}, 8'h07);
    // macrocell outputs take over the pins
    {one_logic_owned, one_use_shared, port_one_macrocell_group, shared_macrocell_group} = 32'hFFF0_33CC;
    two_logic_owned = 8'hFF;
    wr(6'h03, 8'h00);
    wr(6'h13, 8'h00);
    wr(6'h01, 8'h00);
    idle(2);
    chk(one_pin_out, 8'hC3);
    chk(two_pin_out, 8'hCC);
    wr(6'h02, 8'h00);
    wr(6'h22, 8'h00);
    one_oe_term = 8'h0F;
    three_ext = 3'b110;
    idle(8);
    chk(one_pin_oe, 8'h0F);
    chk(one_input_cell, 8'h33);
    chk({5'h00, three_array_in}, 8'h06);
    {clock_pin_assign, select_pin_assign} = 2'b11;
    {three_select_owned, select_term, select_active_low, three_oe_term} = 12'h249;
    idle(2);
    chk({6'h00, logic_clock_input, flash_standby}, 8'h03);
    chk({7'h00, three_pin_out[0]}, 8'h00);
    chk({7'h00, three_pin_oe[0]}, 8'h01);
    select_active_low = 3'b000;
    idle(2);
    chk({7'h00, three_pin_out[0]}, 8'h01);
    {scan_port_enable, scan_pin_out, scan_pin_oe} = 17'h1_5A0F;
    idle(8);
    chk(two_input_cell, 8'h00);
    chk(scan_pin_in, 8'hFA);
    summarize();
  end
endmodule : mio_port_block_tb
`default_nettype wire
